// File: pci_defines.svh
// Offsets, field positions, debug pin mask and reset values of the pin change unit
`ifndef PCI_DEFINES_SVH
`define PCI_DEFINES_SVH
`define PCI_OFF_RISE 4'h0
`define PCI_OFF_FALL 4'h1
`define PCI_OFF_FLAGS 4'h2
`define PCI_OFF_IRQ_EN 4'h3
`define PCI_OFF_IRQ_REQ 4'h4
`define PCI_OFF_STATUS 4'h5
`define PCI_OFF_MASK 4'h6
`define PCI_RST_BYTE 8'h00
`define PCI_DBG_PINS 8'h03
`define PCI_ST_SET 0
`define PCI_ST_CLR 1
`endif

// File: pci_pkg.sv
// Types shared by the pin change unit
package pci_pkg;
  typedef logic [7:0] pci_byte_t;
  typedef logic [3:0] pci_addr_t;
  typedef struct packed {
    logic wr;
    logic rd;
    pci_addr_t addr;
    pci_byte_t wdata;
  } pci_bus_s;
  typedef enum logic [1:0] {
    PCI_RUN = 2'b01,
    PCI_SLEEP = 2'b10
  } pci_pwr_e;
endpackage

// File: pci_edge_det.sv
// Per-pin synchroniser and edge detector
module pci_edge_det (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] rise_o,
  output logic [7:0] fall_o
);
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [7:0] prev_q;
  logic [2:0] fill_q;

  // Edges are ignored until both compare flops hold real pin samples;
  // a pin idling high would otherwise show a false rise after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fill_q <= 3'b000;
    end else begin
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign rise_o[g] = fill_q[2] & sync_q[g] & ~prev_q[g];
      assign fall_o[g] = fill_q[2] & ~sync_q[g] & prev_q[g];
    end
  endgenerate
endmodule // pci_edge_det

// File: pci_top.sv
// Pin change interrupt unit for an 8-bit port
`include "pci_defines.svh"

module pci_top (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] PORTA_PIN_I,
  input wire logic DEBUG_EN_I,
  input wire logic SLEEP_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  input wire pci_pkg::pci_addr_t BUS_ADDR_I,
  input wire pci_pkg::pci_byte_t BUS_WDATA_I,
  output pci_pkg::pci_byte_t BUS_RDATA_O,
  output logic CHANGE_IRQ_O,
  output logic WAKE_O,
  output logic IRQ_O
);
  import pci_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  pci_bus_s bus;
  assign bus = '{wr: BUS_WR_I, rd: BUS_RD_I, addr: BUS_ADDR_I, wdata: BUS_WDATA_I};

  pci_byte_t rise_en_q, fall_en_q, flags_q, flags_d;
  logic irq_en_q;
  logic [1:0] status_q, mask_q;
  logic dbg_meta_q, dbg_q, slp_meta_q, slp_q;
  pci_pwr_e pwr_q;
  logic [7:0] rise, fall, hit, avail;
  logic flag_new;

  pci_edge_det u_edge (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .pin_i(PORTA_PIN_I),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Debug and sleep arrive from other logic domains
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      dbg_meta_q <= 1'b0;
      dbg_q <= 1'b0;
      slp_meta_q <= 1'b0;
      slp_q <= 1'b0;
    end else begin
      dbg_meta_q <= DEBUG_EN_I;
      dbg_q <= dbg_meta_q;
      slp_meta_q <= SLEEP_I;
      slp_q <= slp_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // debugger owns low pins
  assign avail = dbg_q ? ~`PCI_DBG_PINS : 8'hff;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_hit
      assign hit[g] = avail[g] & ((rise_en_q[g] & rise[g]) | (fall_en_q[g] & fall[g]));
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      rise_en_q <= `PCI_RST_BYTE;
      fall_en_q <= `PCI_RST_BYTE;
      irq_en_q <= 1'b0;
      mask_q <= 2'b00;
    end else if (bus.wr) begin
      case (bus.addr)
        `PCI_OFF_RISE: rise_en_q <= bus.wdata;
        `PCI_OFF_FALL: fall_en_q <= bus.wdata;
        `PCI_OFF_IRQ_EN: irq_en_q <= bus.wdata[0];
        `PCI_OFF_MASK: mask_q <= bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    flags_d = flags_q;
    if (bus.wr && bus.addr == `PCI_OFF_FLAGS) begin
      flags_d = bus.wdata;
    end
    flags_d = (flags_d | hit) & avail;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      flags_q <= `PCI_RST_BYTE;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flag_new = |hit;

  // Sticky events: bit 0 set on enabled edge, bit 1 on a flag write that clears a flag; cleared by writing one; set wins
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      status_q <= 2'b00;
    end else begin
      status_q[`PCI_ST_SET] <= flag_new |
        (status_q[`PCI_ST_SET] & ~(bus.wr && bus.addr == `PCI_OFF_STATUS && bus.wdata[`PCI_ST_SET]));
      status_q[`PCI_ST_CLR] <= (bus.wr && bus.addr == `PCI_OFF_FLAGS && |(flags_q & ~bus.wdata)) |
        (status_q[`PCI_ST_CLR] & ~(bus.wr && bus.addr == `PCI_OFF_STATUS && bus.wdata[`PCI_ST_CLR]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      pwr_q <= PCI_RUN;
    end else begin
      case (pwr_q)
        PCI_RUN: if (slp_q) pwr_q <= PCI_SLEEP;
        PCI_SLEEP: if (!slp_q || (flag_new && irq_en_q)) pwr_q <= PCI_RUN;
        default: pwr_q <= PCI_RUN;
      endcase
    end
  end

  // Outputs from flops; summary lags flags by one cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      CHANGE_IRQ_O <= 1'b0;
      WAKE_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      CHANGE_IRQ_O <= irq_en_q & (|flags_q);
      WAKE_O <= (pwr_q == PCI_SLEEP) && flag_new && irq_en_q;
      IRQ_O <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      BUS_RDATA_O <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `PCI_OFF_RISE: BUS_RDATA_O <= rise_en_q;
        `PCI_OFF_FALL: BUS_RDATA_O <= fall_en_q;
        `PCI_OFF_FLAGS: BUS_RDATA_O <= flags_q;
        `PCI_OFF_IRQ_EN: BUS_RDATA_O <= {7'h00, irq_en_q};
        `PCI_OFF_IRQ_REQ: BUS_RDATA_O <= {7'h00, |flags_q};
        `PCI_OFF_STATUS: BUS_RDATA_O <= {6'h00, status_q};
        `PCI_OFF_MASK: BUS_RDATA_O <= {6'h00, mask_q};
        default: BUS_RDATA_O <= 8'h00;
      endcase
    end else begin
      BUS_RDATA_O <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software write to the flag register
  sequence s_flag_write;
    bus.wr && bus.addr == `PCI_OFF_FLAGS;
  endsequence

  // Any enabled edge this cycle
  sequence s_hit_seen;
    hit != 8'h00;
  endsequence

  // Enabled event while the core sleeps
  sequence s_sleep_event;
    pwr_q == PCI_SLEEP && flag_new && irq_en_q;
  endsequence

  chk_flag_sets_on_edge: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (hit != 8'h00) |=> ((flags_q & $past(hit)) == $past(hit))) else $error("enabled edge did not set flag");

  chk_clear_loses_race: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (s_flag_write and s_hit_seen) |=> ((flags_q & $past(hit)) == $past(hit)))
    else $error("edge lost during clear");

  chk_clear_by_zero: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (bus.wr && bus.addr == `PCI_OFF_FLAGS && hit == 8'h00) |=> flags_q == ($past(bus.wdata) & $past(avail)))
    else $error("flag write wrong");

  chk_no_spurious_set: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!bus.wr && hit == 8'h00) |=> flags_q == ($past(flags_q) & $past(avail)))
    else $error("flag set without edge");

  chk_irq_gated: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !irq_en_q |=> !CHANGE_IRQ_O) else $error("interrupt while disabled");

  chk_irq_raised: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (irq_en_q && flags_q != 8'h00) |=> CHANGE_IRQ_O) else $error("interrupt missing");

  chk_debug_blocks: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (dbg_q && $past(dbg_q)) |-> flags_q[1:0] == 2'b00) else $error("debug pins flagged");

  chk_wake_sleep: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_sleep_event |=> (WAKE_O && pwr_q == PCI_RUN))
    else $error("no wake from sleep");

  chk_enable_reset: assert property (@(posedge CORE_CLK_I)
    $past(SYS_RST_I) |-> (rise_en_q == 8'h00 && fall_en_q == 8'h00 && flags_q == 8'h00))
    else $error("reset values wrong");

  chk_summary_read: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (bus.rd && bus.addr == `PCI_OFF_IRQ_REQ) |=> BUS_RDATA_O == {7'h00, $past(|flags_q)})
    else $error("summary readback wrong");

  chk_flags_read: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (bus.rd && bus.addr == `PCI_OFF_FLAGS) |=> BUS_RDATA_O == $past(flags_q))
    else $error("flag readback wrong");

  chk_flags_sticky: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !(bus.wr && bus.addr == `PCI_OFF_FLAGS) |=> ((flags_q & $past(flags_q & avail)) == $past(flags_q & avail)))
    else $error("flag dropped without write");

  chk_rise_en_write: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (bus.wr && bus.addr == `PCI_OFF_RISE) |=> rise_en_q == $past(bus.wdata))
    else $error("rise enable write lost");

  chk_rise_en_read: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (bus.rd && bus.addr == `PCI_OFF_RISE) |=> BUS_RDATA_O == $past(rise_en_q))
    else $error("rise enable readback wrong");

  chk_fall_en_write: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (bus.wr && bus.addr == `PCI_OFF_FALL) |=> fall_en_q == $past(bus.wdata))
    else $error("fall enable write lost");

  chk_fall_en_read: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (bus.rd && bus.addr == `PCI_OFF_FALL) |=> BUS_RDATA_O == $past(fall_en_q))
    else $error("fall enable readback wrong");

  chk_flag_event: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (irq_en_q && hit != 8'h00 && !(bus.wr && bus.addr == `PCI_OFF_IRQ_EN)) |=> ##1 CHANGE_IRQ_O)
    else $error("edge gave no request");

  chk_summary_drops: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (flags_q == 8'h00) |=> !CHANGE_IRQ_O)
    else $error("request without flag");

  chk_status_sticky: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (hit != 8'h00) |=> status_q[`PCI_ST_SET])
    else $error("status event lost");

  chk_irq_out: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    ((status_q & mask_q) != 2'b00) |=> IRQ_O)
    else $error("interrupt line missing");

  chk_irq_out_low: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    ((status_q & mask_q) == 2'b00) |=> !IRQ_O)
    else $error("interrupt line stuck");

  chk_wake_needs_en: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !irq_en_q |=> !WAKE_O)
    else $error("wake while disabled");

  chk_wake_needs_sleep: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (pwr_q != PCI_SLEEP) |=> !WAKE_O)
    else $error("wake while running");

  chk_sleep_entry: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (pwr_q == PCI_RUN && slp_q) |=> pwr_q == PCI_SLEEP)
    else $error("sleep not entered");

  chk_pwr_onehot: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $onehot(pwr_q))
    else $error("power state illegal");

  chk_debug_mask_write: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (dbg_q && bus.wr && bus.addr == `PCI_OFF_FLAGS) |=> flags_q[1:0] == 2'b00)
    else $error("debug pin flag written");
endmodule // pci_top

// File: pci_port_model.sv
// Port pin model standing in for the outside world
module pci_port_model (
  input wire logic clk_i,
  input wire logic [7:0] lvl_i,
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins change by non-blocking update on the edge, so nothing samples them mid-edge
  always_ff @(posedge clk_i) begin
    pin_o <= lvl_i;
  end
endmodule // pci_port_model

// File: tb_pci_top.sv
// Self-checking bench for the pin change unit
`include "pci_defines.svh"
module tb_pci_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pci_pkg::*;
  logic clk, rst, dbg, slp, wr, rd, chg, wake, irq;
  pci_addr_t addr;
  pci_byte_t wd, rdat, lvl, pins, v;
  int bad_count, checked, cyc, wakes;
  //////////////////////////////////////////////////////////////////////////////
  pci_top u_pci_top (.CORE_CLK_I(clk), .SYS_RST_I(rst), .PORTA_PIN_I(pins), .DEBUG_EN_I(dbg),
    .SLEEP_I(slp), .BUS_WR_I(wr), .BUS_RD_I(rd), .BUS_ADDR_I(addr), .BUS_WDATA_I(wd),
    .BUS_RDATA_O(rdat), .CHANGE_IRQ_O(chg), .WAKE_O(wake), .IRQ_O(irq));
  pci_port_model u_pci_port_model (.clk_i(clk), .lvl_i(lvl), .pin_o(pins));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard, run needs just over a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic cmp8(input pci_byte_t g, input pci_byte_t e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t bit %b want %b", $time, g, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrr(input pci_addr_t a, input pci_byte_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdr(input pci_addr_t a, output pci_byte_t d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask
  task automatic chk(input pci_addr_t a, input pci_byte_t e);
    rdr(a, v);
    cmp8(v, e);
  endtask
  task automatic pin(input pci_byte_t p);
    @(posedge clk);
    lvl <= p;
    settle(6);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {dbg, slp, wr, rd} = 4'h0;
    addr = 4'h0;
    wd = 8'h00;
    lvl = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk(`PCI_OFF_RISE, 8'h00);
    chk(`PCI_OFF_FALL, 8'h00);
    chk(`PCI_OFF_FLAGS, 8'h00);
    chk(4'hf, 8'h00);
    wrr(`PCI_OFF_RISE, 8'hf0);
    wrr(`PCI_OFF_FALL, 8'h3c);
    chk(`PCI_OFF_RISE, 8'hf0);
    chk(`PCI_OFF_FALL, 8'h3c);
    pin(8'hff);
    chk(`PCI_OFF_FLAGS, 8'hf0);
    cmp1(chg, 1'b0);
    chk(`PCI_OFF_IRQ_REQ, 8'h01);
    rdr(`PCI_OFF_FLAGS, v);
    wrr(`PCI_OFF_FLAGS, (v ^ 8'hff) & v);
    chk(`PCI_OFF_FLAGS, 8'h00);
    chk(`PCI_OFF_IRQ_REQ, 8'h00);
    pin(8'h00);
    chk(`PCI_OFF_FLAGS, 8'h3c);
    wrr(`PCI_OFF_IRQ_EN, 8'h01);
    settle(2);
    cmp1(chg, 1'b1);
    wrr(`PCI_OFF_FLAGS, 8'h00);
    // Clear lands on the edge that detects the rise
    lvl <= 8'hff;
    repeat (2) @(posedge clk);
    wrr(`PCI_OFF_FLAGS, 8'h00);
    chk(`PCI_OFF_FLAGS, 8'hf0);
    cmp1(irq, 1'b0);
    wrr(`PCI_OFF_MASK, 8'h01);
    settle(2);
    cmp1(irq, 1'b1);
    chk(`PCI_OFF_STATUS, 8'h03);
    wrr(`PCI_OFF_STATUS, 8'h03);
    settle(2);
    cmp1(irq, 1'b0);
    chk(`PCI_OFF_STATUS, 8'h00);
    wrr(`PCI_OFF_MASK, 8'h02);
    wrr(`PCI_OFF_FLAGS, 8'h00);
    settle(2);
    cmp1(irq, 1'b1);
    @(posedge clk);
    dbg <= 1'b1;
    wrr(`PCI_OFF_FALL, 8'hff);
    wrr(`PCI_OFF_FLAGS, 8'h00);
    pin(8'h00);
    chk(`PCI_OFF_FLAGS, 8'hfc);
    @(posedge clk);
    dbg <= 1'b0;
    slp <= 1'b1;
    wrr(`PCI_OFF_RISE, 8'hff);
    pin(8'hff);
    cmp8(pci_byte_t'(wakes), 8'h01);
    wrr(`PCI_OFF_IRQ_EN, 8'h00);
    pin(8'h00);
    cmp8(pci_byte_t'(wakes), 8'h01);
    cmp1(chg, 1'b0);
    tally_and_finish();
  end
endmodule // tb_pci_top
